// ---- pkg/adcsq_pkg.sv ----
// Functional notes
// [R1] Pin select bit set makes pin analog
// [R2] Analog pin drops its pull-up
// [R3] Analog pin overrides port direction
// [R4] Software programs clock divider before converting
// [R5] Power-off bit low enables converter
// [R6] Channel select routes one analog input
// [R7] Software enables interrupts, or polls instead
// [R8] Start pulse 0-1-0 begins conversion
// [R9] Done flag falls low, result readable
// [R10] Vector only if enabled, stack not full
// [R11] Conversion takes sixteen converter clocks
// [R12] Conversion runs on without the processor
// [R13] No analog pins powers converter down
// [R14] Power-off bit forces converter down
// [R15] Result is 12-bit unsigned code
// [R16] Code transitions shifted half step down
// [R17] Start held high holds converter reset
// [R18] Every completion sets interrupt request flag
// [R19] Divider select decode, 011 and 111 undefined
// [R20] Result bytes stable, fixed split alignment
package adcsq_pkg;
  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLKPWR = 8'h04;
  localparam logic [7:0] ADDR_RES_LO = 8'h08;
  localparam logic [7:0] ADDR_RES_HI = 8'h0c;
  localparam logic [7:0] ADDR_IRQ = 8'h10;
  localparam logic [7:0] ADDR_PORT = 8'h14;
  // Control register fields
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_DONE_BIT = 6;
  localparam int CTRL_PINSEL_LSB = 2;
  localparam int CTRL_CHAN_LSB = 0;
  // Clock/power register fields
  localparam int CP_POWER_OFF_BIT = 6;
  localparam int CP_DIV_LSB = 0;
  // Irq register fields
  localparam int IRQ_GLOBAL_BIT = 0;
  localparam int IRQ_MULTI_BIT = 1;
  localparam int IRQ_CONV_EN_BIT = 2;
  localparam int IRQ_FLAG_BIT = 3;
  // Port register fields
  localparam int PORT_DIR_LSB = 0;
  localparam int PORT_PULL_LSB = 4;
  localparam int PORT_OUT_LSB = 8;
  // Reset values
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic POWER_OFF_RESET = 1'b0;
  localparam logic [3:0] DIR_RESET = 4'hf;
  // Conversion length in converter clocks
  localparam logic [4:0] CONV_CLOCKS = 5'h10;
  localparam int RESULT_W = 12;
  localparam logic [11:0] CODE_FULL = 12'hfff;
  // Divider ratio codes
  localparam logic [2:0] DIV_2 = 3'h0;
  localparam logic [2:0] DIV_8 = 3'h1;
  localparam logic [2:0] DIV_32 = 3'h2;
  localparam logic [2:0] DIV_1 = 3'h4;
  localparam logic [2:0] DIV_4 = 3'h5;
  localparam logic [2:0] DIV_16 = 3'h6;
  // Conversion sequence, Gray along idle-armed-busy
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'b00,
    ADCSQ_ARMED = 2'b01,
    ADCSQ_BUSY = 2'b11
  } adcsq_state_t;
endpackage

// ---- rtl/adcsq_clkdiv.sv ----
`timescale 1ns/10ps
`default_nettype none
module adcsq_clkdiv (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [2:0] div_sel,
  // Converter clock tick
  output logic tick
);
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } adcsq_div_t;

  adcsq_div_t s_reg, s_next;

  // Terminal count for each divider ratio, undefined codes stop the clock
  function automatic logic [5:0] adcsq_term(input logic [2:0] sel);
    logic [5:0] t;
    t = 6'h00;
    case (sel)
      adcsq_pkg::DIV_1: t = 6'h01;
      adcsq_pkg::DIV_2: t = 6'h02;
      adcsq_pkg::DIV_4: t = 6'h04;
      adcsq_pkg::DIV_8: t = 6'h08;
      adcsq_pkg::DIV_16: t = 6'h10;
      adcsq_pkg::DIV_32: t = 6'h20;
      default: t = 6'h00;
    endcase
    return t;
  endfunction

  // Divider counter, restarted whenever the converter is not running
  always_comb begin
    logic [5:0] term;
    term = adcsq_term(div_sel); // [R19]
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run || term == 6'h00) begin
      s_next.cnt = 5'h00;
    end else if ({1'b0, s_reg.cnt} == term - 6'h01) begin
      s_next.cnt = 5'h00;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule
`default_nettype wire

// ---- rtl/adcsq_top.sv ----
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module adcsq_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  input wire logic [11:0] sar_code,
  output logic [1:0] analog_channel,
  output logic converter_power_on,
  output logic sample_hold,
  // Shared port pins
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic [3:0] pin_pullup_en,
  output logic [3:0] pin_analog_en,
  output logic [3:0] port_data_in,
  // Interrupt handshake with the core
  input wire logic stack_full,
  input wire logic irq_ack,
  output logic irq_request
);
  typedef struct packed {
    adcsq_pkg::adcsq_state_t state;
    logic start;
    logic done_n;
    logic [3:0] analog_pin_select;
    logic [1:0] channel_select;
    logic [2:0] conv_clock_divider_sel;
    logic converter_power_off;
    logic global_irq_enable;
    logic multi_function_irq_enable;
    logic converter_irq_enable;
    logic irq_flag;
    logic [3:0] port_direction_ctrl;
    logic [3:0] pullup_ctrl;
    logic [3:0] port_out;
    logic [4:0] clocks;
    logic [11:0] result;
    logic [31:0] rdata;
  } adcsq_regs_t;

  adcsq_regs_t s_reg, s_next;
  logic powered;
  logic tick;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // Converter is powered only with analog pins chosen and power-off low
  assign powered = !s_reg.converter_power_off && (s_reg.analog_pin_select != 4'h0); // [R5] [R13] [R14]

  // Converter clock divider runs only during a conversion
  adcsq_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(s_reg.state == adcsq_pkg::ADCSQ_BUSY),
    .div_sel(s_reg.conv_clock_divider_sel),
    .tick(tick)
  );

  // Zero-wait access; read data is fetched in the setup phase so that the
  // flopped prdata already stands when the master samples the access edge
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // Decode of the mapped offsets
  function automatic logic adcsq_mapped(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a == adcsq_pkg::ADDR_CTRL) begin
      ok = 1'b1;
    end else if (a == adcsq_pkg::ADDR_CLKPWR) begin
      ok = 1'b1;
    end else if (a == adcsq_pkg::ADDR_RES_LO) begin
      ok = 1'b1;
    end else if (a == adcsq_pkg::ADDR_RES_HI) begin
      ok = 1'b1;
    end else if (a == adcsq_pkg::ADDR_IRQ) begin
      ok = 1'b1;
    end else if (a == adcsq_pkg::ADDR_PORT) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  assign addr_ok = adcsq_mapped(paddr);
  assign pslverr = psel && penable && !addr_ok;

  // Read mux value for the current address
  function automatic logic [31:0] adcsq_read(input adcsq_regs_t r, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == adcsq_pkg::ADDR_CTRL) begin
      d[adcsq_pkg::CTRL_START_BIT] = r.start;
      d[adcsq_pkg::CTRL_DONE_BIT] = r.done_n;
      d[adcsq_pkg::CTRL_PINSEL_LSB +: 4] = r.analog_pin_select;
      d[adcsq_pkg::CTRL_CHAN_LSB +: 2] = r.channel_select;
    end else if (a == adcsq_pkg::ADDR_CLKPWR) begin
      d[adcsq_pkg::CP_POWER_OFF_BIT] = r.converter_power_off;
      d[adcsq_pkg::CP_DIV_LSB +: 3] = r.conv_clock_divider_sel;
    end else if (a == adcsq_pkg::ADDR_RES_LO) begin
      d[7:0] = r.result[7:0]; // [R20]
    end else if (a == adcsq_pkg::ADDR_RES_HI) begin
      d[3:0] = r.result[11:8]; // [R20]
    end else if (a == adcsq_pkg::ADDR_IRQ) begin
      d[adcsq_pkg::IRQ_GLOBAL_BIT] = r.global_irq_enable;
      d[adcsq_pkg::IRQ_MULTI_BIT] = r.multi_function_irq_enable;
      d[adcsq_pkg::IRQ_CONV_EN_BIT] = r.converter_irq_enable;
      d[adcsq_pkg::IRQ_FLAG_BIT] = r.irq_flag;
    end else if (a == adcsq_pkg::ADDR_PORT) begin
      d[adcsq_pkg::PORT_DIR_LSB +: 4] = r.port_direction_ctrl;
      d[adcsq_pkg::PORT_PULL_LSB +: 4] = r.pullup_ctrl;
      d[adcsq_pkg::PORT_OUT_LSB +: 4] = r.port_out;
    end
    return d;
  endfunction

  // Next state: register writes, start protocol and conversion sequence
  always_comb begin
    logic new_start;
    logic done_evt;
    new_start = s_reg.start;
    done_evt = 1'b0;
    s_next = s_reg;
    if (rd_en && addr_ok) begin
      s_next.rdata = adcsq_read(s_reg, paddr);
    end
    if (wr_en) begin
      if (paddr == adcsq_pkg::ADDR_CTRL) begin
        new_start = pwdata[adcsq_pkg::CTRL_START_BIT];
        s_next.start = new_start;
        s_next.analog_pin_select = pwdata[adcsq_pkg::CTRL_PINSEL_LSB +: 4]; // [R1]
        s_next.channel_select = pwdata[adcsq_pkg::CTRL_CHAN_LSB +: 2]; // [R6]
      end else if (paddr == adcsq_pkg::ADDR_CLKPWR) begin
        s_next.converter_power_off = pwdata[adcsq_pkg::CP_POWER_OFF_BIT];
        s_next.conv_clock_divider_sel = pwdata[adcsq_pkg::CP_DIV_LSB +: 3]; // [R19]
      end else if (paddr == adcsq_pkg::ADDR_IRQ) begin
        s_next.global_irq_enable = pwdata[adcsq_pkg::IRQ_GLOBAL_BIT];
        s_next.multi_function_irq_enable = pwdata[adcsq_pkg::IRQ_MULTI_BIT];
        s_next.converter_irq_enable = pwdata[adcsq_pkg::IRQ_CONV_EN_BIT];
        // Software may clear the request flag; writing one has no effect
        if (!pwdata[adcsq_pkg::IRQ_FLAG_BIT]) begin
          s_next.irq_flag = 1'b0;
        end
      end else if (paddr == adcsq_pkg::ADDR_PORT) begin
        s_next.port_direction_ctrl = pwdata[adcsq_pkg::PORT_DIR_LSB +: 4];
        s_next.pullup_ctrl = pwdata[adcsq_pkg::PORT_PULL_LSB +: 4];
        s_next.port_out = pwdata[adcsq_pkg::PORT_OUT_LSB +: 4];
      end
    end
    // Sequencer: rise resets, fall starts, sixteen ticks convert
    case (s_reg.state)
      adcsq_pkg::ADCSQ_IDLE: begin
        if (!s_reg.start && new_start) begin
          s_next.state = adcsq_pkg::ADCSQ_ARMED; // [R8]
        end
      end
      adcsq_pkg::ADCSQ_ARMED: begin
        s_next.done_n = 1'b1; // [R17]
        if (!new_start && powered) begin
          s_next.state = adcsq_pkg::ADCSQ_BUSY; // [R8] [R12]
          s_next.clocks = 5'h00;
        end else if (!new_start) begin
          s_next.state = adcsq_pkg::ADCSQ_IDLE;
        end
      end
      adcsq_pkg::ADCSQ_BUSY: begin
        if (new_start) begin
          s_next.state = adcsq_pkg::ADCSQ_ARMED; // [R17]
        end else if (!powered) begin
          s_next.state = adcsq_pkg::ADCSQ_IDLE; // [R14]
        end else if (tick) begin
          if (s_reg.clocks == adcsq_pkg::CONV_CLOCKS - 5'h01) begin
            s_next.state = adcsq_pkg::ADCSQ_IDLE; // [R11]
            done_evt = 1'b1;
          end else begin
            s_next.clocks = s_reg.clocks + 5'h01;
          end
        end
      end
      default: s_next.state = adcsq_pkg::ADCSQ_IDLE;
    endcase
    // Completion latches the code and flags the end; the set beats a clear
    if (done_evt) begin
      s_next.result = sar_code; // [R9] [R15] [R16] [R20]
      s_next.done_n = 1'b0; // [R9]
      s_next.irq_flag = 1'b1; // [R18]
    end
    // Core acknowledge clears the flag unless a new completion arrives
    if (irq_ack && irq_request && !done_evt) begin
      s_next.irq_flag = 1'b0;
      s_next.global_irq_enable = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.state <= adcsq_pkg::ADCSQ_IDLE;
      s_reg.done_n <= 1'b1;
      s_reg.conv_clock_divider_sel <= adcsq_pkg::DIV_RESET;
      s_reg.converter_power_off <= adcsq_pkg::POWER_OFF_RESET;
      s_reg.port_direction_ctrl <= adcsq_pkg::DIR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Bus outputs
  assign prdata = s_reg.rdata;

  // Analog front-end controls; the quantiser offset lives in the analog macro
  assign analog_channel = s_reg.channel_select; // [R6]
  assign converter_power_on = powered; // [R13] [R14]
  assign sample_hold = (s_reg.state == adcsq_pkg::ADCSQ_BUSY);

  // Pin muxing: analog use wins over direction and pull-up settings
  assign pin_analog_en = s_reg.analog_pin_select; // [R1]
  assign pin_oe = s_reg.port_direction_ctrl & ~s_reg.analog_pin_select; // [R3]
  assign pin_pullup_en = s_reg.pullup_ctrl & ~s_reg.analog_pin_select; // [R2]
  assign pin_out = s_reg.port_out;
  assign port_data_in = pin_in & ~s_reg.analog_pin_select; // [R1]

  // Vector request gated by all enables and a free stack slot
  assign irq_request = s_reg.irq_flag && s_reg.converter_irq_enable
    && s_reg.multi_function_irq_enable && s_reg.global_irq_enable && !stack_full; // [R10]
endmodule
`default_nettype wire

// ---- test/adcsq_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module adcsq_monitor (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  // Pins and converter
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_pullup_en,
  input wire logic [3:0] pin_analog_en,
  input wire logic [3:0] port_data_in,
  input wire logic converter_power_on,
  input wire logic sample_hold,
  // Interrupt handshake
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic irq_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Analog pins never drive, pull or feed the port
  a_dir_override: assert property ((pin_oe & pin_analog_en) == 4'h0)
    else $error("analog pin still driven");
  a_pull_drop: assert property ((pin_pullup_en & pin_analog_en) == 4'h0)
    else $error("analog pin still pulled up");
  a_port_mask: assert property (port_data_in == (pin_in & ~pin_analog_en))
    else $error("port input not masked");
  // Converter power follows pins and power-off bit
  a_no_pins_off: assert property (pin_analog_en == 4'h0 |-> !converter_power_on)
    else $error("converter powered with no analog pin");
  a_off_abort: assert property (sample_hold && !converter_power_on |=> !sample_hold)
    else $error("conversion runs while powered down");
  // Even the fastest clock gives at least eight cycles of busy
  a_busy_min: assert property ($rose(sample_hold) |-> sample_hold [*8])
    else $error("conversion ended too early");
  // Request is blocked by a full stack and dropped on acknowledge
  a_stack_block: assert property (stack_full |-> !irq_request)
    else $error("request with full stack");
  a_ack_clears: assert property (irq_ack && irq_request |=> !irq_request)
    else $error("request kept after acknowledge");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule
bind adcsq_top adcsq_monitor i_adcsq_monitor (.pclk, .presetn, .psel, .penable, .pslverr,
  .pin_in, .pin_oe, .pin_pullup_en, .pin_analog_en, .port_data_in, .converter_power_on,
  .sample_hold, .stack_full, .irq_ack, .irq_request);
`default_nettype wire

// ---- test/adcsq_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module adcsq_top_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic stack_full = 1'b0, irq_ack = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [11:0] sar_code = 12'h000;
  logic [3:0] pin_in = 4'h6, pin_out, pin_oe, pin_pullup_en, pin_analog_en, port_data_in;
  logic [1:0] analog_channel;
  logic pready, pslverr, converter_power_on, sample_hold, irq_request;
  int n_fail = 0, comparisons = 0;
  int rs [6] = '{2, 8, 32, 1, 4, 16};
  adcsq_top i_adcsq_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sar_code, .analog_channel, .converter_power_on, .sample_hold, .pin_in,
    .pin_out, .pin_oe, .pin_pullup_en, .pin_analog_en, .port_data_in, .stack_full, .irq_ack,
    .irq_request);
  // 50 ns period
  always #25 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; response and data are taken at the accepting edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write, then let the new state settle before any check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
    @(negedge pclk);
  endtask
  // Read data stands in the access phase and is taken at the accepting edge
  task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic t_reset();
    rdreg(adcsq_pkg::ADDR_CTRL, 32'h40);
    rdreg(adcsq_pkg::ADDR_CLKPWR, 32'h0);
    rdreg(adcsq_pkg::ADDR_PORT, 32'hf);
    chk(converter_power_on, 1'b0);
    apb(8'h18, 1'b0, 32'h0);
    chk(err, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_pins();
    wr(adcsq_pkg::ADDR_PORT, 32'h5ff);
    wr(adcsq_pkg::ADDR_CTRL, 32'h14);
    chk(pin_analog_en, 4'h5);
    chk(pin_out, 4'h5);
    chk(pin_oe, 4'ha);
    chk(pin_pullup_en, 4'ha);
    chk(port_data_in, 4'h2);
    chk(converter_power_on, 1'b1);
    wr(adcsq_pkg::ADDR_CLKPWR, 32'h40);
    chk(converter_power_on, 1'b0);
    wr(adcsq_pkg::ADDR_CLKPWR, 32'h0);
    wr(adcsq_pkg::ADDR_CTRL, 32'h0);
    chk(pin_oe, 4'hf);
    $display("pin test done");
  endtask
  // Start pulse on channel c, busy window timed against sixteen converter clocks
  task automatic t_conv(input logic [2:0] dv, input int r, input logic [1:0] c);
    int k;
    k = 0;
    @(posedge pclk);
    sar_code <= {2'h2, c, 8'h5a};
    wr(adcsq_pkg::ADDR_IRQ, 32'h0);
    wr(adcsq_pkg::ADDR_CLKPWR, {29'h0, dv});
    wr(adcsq_pkg::ADDR_CTRL, {24'h0, 6'h2f, c});
    rdreg(adcsq_pkg::ADDR_CTRL, {24'h0, 6'h3f, c});
    chk(sample_hold, 1'b0);
    wr(adcsq_pkg::ADDR_CTRL, {24'h0, 6'h0f, c});
    // Look on the falling edge, where the busy state has settled
    while (sample_hold !== 1'b1 && k < 8) begin
      @(negedge pclk);
      k++;
    end
    while (sample_hold === 1'b1 && k < 600) begin
      @(negedge pclk);
      k++;
    end
    chk(k >= 16 * r && k <= 16 * r + 4, 1'b1);
    chk(analog_channel, c);
    rdreg(adcsq_pkg::ADDR_CTRL, {24'h0, 6'h0f, c});
    rdreg(adcsq_pkg::ADDR_RES_LO, 32'h5a);
    @(posedge pclk);
    sar_code <= 12'h000;
    rdreg(adcsq_pkg::ADDR_RES_HI, {28'h0, 2'h2, c});
    rdreg(adcsq_pkg::ADDR_IRQ, 32'h8);
    $display("conversion test done, ratio %0d", r);
  endtask
  task automatic t_irq();
    wr(adcsq_pkg::ADDR_IRQ, 32'hf);
    chk(irq_request, 1'b1);
    @(posedge pclk);
    stack_full <= 1'b1;
    @(negedge pclk);
    chk(irq_request, 1'b0);
    @(posedge pclk);
    stack_full <= 1'b0;
    wr(adcsq_pkg::ADDR_IRQ, 32'hd);
    chk(irq_request, 1'b0);
    wr(adcsq_pkg::ADDR_IRQ, 32'hf);
    @(posedge pclk);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    @(negedge pclk);
    chk(irq_request, 1'b0);
    rdreg(adcsq_pkg::ADDR_IRQ, 32'h6);
    // Undefined divider stalls; power-off then aborts without a done flag
    wr(adcsq_pkg::ADDR_CLKPWR, 32'h7);
    wr(adcsq_pkg::ADDR_CTRL, 32'hbc);
    wr(adcsq_pkg::ADDR_CTRL, 32'h3c);
    repeat (40) @(posedge pclk);
    @(negedge pclk);
    chk(sample_hold, 1'b1);
    wr(adcsq_pkg::ADDR_CLKPWR, 32'h42);
    @(negedge pclk);
    chk(sample_hold, 1'b0);
    rdreg(adcsq_pkg::ADDR_CTRL, 32'h7c);
    $display("interrupt test done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Whole run needs under two thousand cycles; this margin only catches a hang
  initial begin
    #(50 * 20000);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pins();
    for (int i = 0; i < 6; i++) begin
      t_conv(i < 3 ? 3'(i) : 3'(i + 1), rs[i], 2'(i));
    end
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
